// ### fhc_cfg.svh
// Purpose: constants of the cascade-capable fifo host controller
// Assumes: 125 MHz clk, slowest speed grade timing on the fifo pins
// Notes:   times in ns as printed, cycle counts derived below
`ifndef FHC_CFG_SVH
`define FHC_CFG_SVH

// ----------------------------------------------------------------
// clock and pin timing
// ----------------------------------------------------------------
`define FHC_CLK_NS        8
`define FHC_T_PULSE_NS    200
`define FHC_T_RECOV_NS    35
`define FHC_T_FLAG_NS     195
`define FHC_T_RST_NS      200
`define FHC_PULSE_CYC  ((`FHC_T_PULSE_NS + `FHC_CLK_NS - 1) / `FHC_CLK_NS)
`define FHC_RECOV_CYC  ((`FHC_T_RECOV_NS + `FHC_CLK_NS - 1) / `FHC_CLK_NS)
`define FHC_FLAG_CYC   ((`FHC_T_FLAG_NS + `FHC_CLK_NS - 1) / `FHC_CLK_NS + 4)
`define FHC_RST_CYC    ((`FHC_T_RST_NS + `FHC_CLK_NS - 1) / `FHC_CLK_NS)

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define FHC_OFF_CTRL      4'h0
`define FHC_OFF_WDATA     4'h4
`define FHC_OFF_RDCMD     4'h8
`define FHC_OFF_STATUS    4'hC
`define FHC_CTRL_DEPTH    0
`define FHC_CTRL_NOTFIRST 1
`define FHC_CTRL_RESET    2
`define FHC_CTRL_REREAD   3
`define FHC_ST_BUSY       0
`define FHC_ST_FULL       1
`define FHC_ST_EMPTY      2
`define FHC_ST_HALF       3
`define FHC_ST_READY      4
`define FHC_ST_CASC_LSB   8
`define FHC_RD_VALID      16
`define FHC_RESP_OKAY     2'h0
`define FHC_RESP_SLVERR   2'h2

`endif

// ### fhc_pkg.sv
// Purpose: types of the fifo host controller
// Assumes: nothing
// Notes:   constants live in fhc_cfg.svh
package fhc_pkg;
  typedef logic [8:0] fhc_word_t;
  typedef enum logic [1:0] {FHC_OP_WR, FHC_OP_RD, FHC_OP_RST, FHC_OP_RT}
    fhc_op_t;
  typedef enum logic {FHC_IDLE, FHC_BUSY} fhc_state_t;
endpackage : fhc_pkg

// ### fhc_strobe_if.sv
// Purpose: request and phase signals between host and strobe timer
// Assumes: one clock
// Notes:   counts are in clk cycles, at least one
`timescale 1ns/1ps
interface fhc_strobe_if;
  logic       start;
  logic [7:0] lowCycles;
  logic [7:0] recCycles;
  logic       low;
  logic       lowEnd;
  logic       done;
  logic       busy;
  modport ctrl (output start, lowCycles, recCycles,
                input  low, lowEnd, done, busy);
  modport gen  (input  start, lowCycles, recCycles,
                output low, lowEnd, done, busy);
endinterface : fhc_strobe_if

// ### fhc_sync.sv
// Purpose: three-stage synchroniser for fifo flag pins
// Assumes: inputs asynchronous to clk
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ps
module fhc_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut
);
  logic [W-1:0] s1Reg;
  logic [W-1:0] s2Reg;
  logic [W-1:0] s3Reg;
  // reset to all ones: flags idle high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1Reg  <= '1;
      s2Reg  <= '1;
      s3Reg  <= '1;
      pinOut <= '1;
    end else begin
      s1Reg <= pinIn;
      s2Reg <= s1Reg;
      s3Reg <= s2Reg;
      for (int i = 0; i < W; i++) begin
        if (s2Reg[i] == s3Reg[i]) begin
          pinOut[i] <= s3Reg[i];
        end
      end
    end
  end
endmodule : fhc_sync

// ### fhc_strobe_gen.sv
// Purpose: times one low strobe followed by a recovery gap
// Assumes: start only while not busy
// Notes:   lowEnd marks the last low cycle, done the end of recovery
`timescale 1ns/1ps
module fhc_strobe_gen (
  input  wire logic clk,
  input  wire logic rst_n,
  fhc_strobe_if.gen sif
);
  logic [7:0] cntReg;
  logic       lowReg;
  logic       recReg;
  logic       doneReg;
  wire        cntZero = (cntReg == 8'h00);

  assign sif.low    = lowReg;
  assign sif.lowEnd = lowReg && cntZero;
  assign sif.done   = doneReg;
  assign sif.busy   = lowReg || recReg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cntReg  <= 8'h00;
      lowReg  <= 1'b0;
      recReg  <= 1'b0;
      doneReg <= 1'b0;
    end else begin
      doneReg <= 1'b0;
      if (sif.start && !sif.busy) begin
        lowReg <= 1'b1;
        cntReg <= sif.lowCycles - 8'h01;
      end else if (lowReg && cntZero) begin
        lowReg <= 1'b0;
        recReg <= 1'b1;
        cntReg <= sif.recCycles - 8'h01;
      end else if (recReg && cntZero) begin
        recReg  <= 1'b0;
        doneReg <= 1'b1;
      end else if (sif.busy) begin
        cntReg <= cntReg - 8'h01;
      end
    end
  end
endmodule : fhc_strobe_gen

// ### fhc_host.sv
// Purpose: AXI4-Lite driven controller for a cascadable async fifo
// Assumes: all fifos of a width group share these strobes
// Notes:   one fifo operation at a time; flags read from one device
`timescale 1ns/1ps
`include "fhc_cfg.svh"
module fhc_host (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [3:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [3:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   write_n,
  output logic                   read_n,
  output logic                   reset_n,
  output logic                   first_load_n,
  output logic                   cascade_in_n,
  output fhc_pkg::fhc_word_t     fifoWData,
  input  wire fhc_pkg::fhc_word_t fifoRData,
  input  wire logic              no_room_n,
  input  wire logic              nothing_stored_n,
  input  wire logic              half_level_n
);
  import fhc_pkg::*;

  // ----------------------------------------------------------------
  // flag synchronisers
  // ----------------------------------------------------------------
  logic [2:0] flagSync;
  fhc_sync #(.W(3)) uSync (
    .clk    (clk),
    .rst_n  (rst_n),
    .pinIn  ({half_level_n, nothing_stored_n, no_room_n}),
    .pinOut (flagSync)
  );
  wire roomOk  = flagSync[0];
  wire dataOk  = flagSync[1];
  wire halfSyn = flagSync[2];

  // ----------------------------------------------------------------
  // strobe timer
  // ----------------------------------------------------------------
  fhc_strobe_if sif ();
  fhc_strobe_gen uGen (
    .clk   (clk),
    .rst_n (rst_n),
    .sif   (sif.gen)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fhc_state_t stateReg;
  fhc_op_t    opReg;
  logic       depthReg;
  logic       notFirstReg;
  logic       readyReg;
  logic       rdValidReg;
  fhc_word_t  rdDataReg;
  logic [7:0] cascCntReg;
  logic       halfPrevReg;
  logic [3:0] awAddrReg;
  logic       awHeldReg;
  logic [31:0] wDataReg;
  logic [3:0] wStrbReg;
  logic       wHeldReg;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  wire doWrite   = awHeldReg && wHeldReg && !s_axi_bvalid;
  wire hitCtrl   = (awAddrReg == `FHC_OFF_CTRL);
  wire hitWData  = (awAddrReg == `FHC_OFF_WDATA);
  wire hitRdCmd  = (awAddrReg == `FHC_OFF_RDCMD);
  wire hitStatus = (awAddrReg == `FHC_OFF_STATUS);
  wire lane0     = wStrbReg[0];
  wire idle      = (stateReg == FHC_IDLE);
  wire reqRst    = hitCtrl && lane0 && wDataReg[`FHC_CTRL_RESET];
  wire reqRt     = hitCtrl && lane0 && wDataReg[`FHC_CTRL_REREAD];
  wire reqWr     = hitWData && lane0;
  wire reqRd     = hitRdCmd && lane0 && wDataReg[0];
  // refused: busy, not yet reset, flag says no, or reread in depth mode
  wire badWr     = reqWr && (!idle || !readyReg || !roomOk);
  wire badRd     = reqRd && (!idle || !readyReg || !dataOk);
  wire badRt     = reqRt && (!idle || !readyReg || depthReg);
  wire badRst    = reqRst && !idle;
  wire unmapped  = !(hitCtrl || hitWData || hitRdCmd || hitStatus);
  wire refuse    = badWr || badRd || badRt || badRst || unmapped;
  wire goStart   = doWrite && !refuse && (reqRst || reqRt || reqWr || reqRd);
  wire fhc_op_t goOp = reqRst ? FHC_OP_RST :
                       reqRt  ? FHC_OP_RT  :
                       reqWr  ? FHC_OP_WR  : FHC_OP_RD;
  // a refused command leaves the mode bits untouched as well
  wire cfgWrite  = doWrite && hitCtrl && lane0 && !refuse && idle;

  // flag settle time is folded into the gap after data strobes
  assign sif.start     = goStart;
  assign sif.lowCycles = (goOp == FHC_OP_RST) ? 8'(`FHC_RST_CYC)
                                              : 8'(`FHC_PULSE_CYC);
  assign sif.recCycles = (goOp == FHC_OP_WR || goOp == FHC_OP_RD)
                         ? 8'(`FHC_FLAG_CYC) : 8'(`FHC_RECOV_CYC);

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  logic [31:0] statusWord;
  always_comb begin
    statusWord = 32'h0000_0000;
    statusWord[`FHC_ST_BUSY]  = !idle;
    statusWord[`FHC_ST_FULL]  = !roomOk;
    statusWord[`FHC_ST_EMPTY] = !dataOk;
    // in depth mode the shared pin counts cascade pulses instead
    statusWord[`FHC_ST_HALF]  = !depthReg && !halfSyn;
    statusWord[`FHC_ST_READY] = readyReg;
    statusWord[`FHC_ST_CASC_LSB +: 8] = cascCntReg;
  end
  wire [31:0] ctrlWord = {30'h0000_0000, notFirstReg, depthReg};
  wire [31:0] rdWord   = {15'h0000, rdValidReg, 7'h00, rdDataReg};
  wire        arHitOk  = (s_axi_araddr == `FHC_OFF_CTRL) ||
                         (s_axi_araddr == `FHC_OFF_RDCMD) ||
                         (s_axi_araddr == `FHC_OFF_STATUS);
  wire [31:0] arData   = (s_axi_araddr == `FHC_OFF_CTRL)  ? ctrlWord :
                         (s_axi_araddr == `FHC_OFF_RDCMD) ? rdWord :
                         (s_axi_araddr == `FHC_OFF_STATUS) ? statusWord :
                         32'h0000_0000;
  wire        halfFell = halfPrevReg && !halfSyn;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awHeldReg     <= 1'b0;
      awAddrReg     <= 4'h0;
      wHeldReg      <= 1'b0;
      wDataReg      <= 32'h0000_0000;
      wStrbReg      <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FHC_RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `FHC_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeldReg <= 1'b1;
        awAddrReg <= {s_axi_awaddr[3:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeldReg <= 1'b1;
        wDataReg <= s_axi_wdata;
        wStrbReg <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeldReg    <= 1'b0;
        wHeldReg     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= refuse ? `FHC_RESP_SLVERR : `FHC_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= arData;
        s_axi_rresp  <= arHitOk ? `FHC_RESP_OKAY : `FHC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !awHeldReg && !s_axi_bvalid;
  assign s_axi_wready  = !wHeldReg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // ----------------------------------------------------------------
  // operation sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stateReg    <= FHC_IDLE;
      opReg       <= FHC_OP_RST;
      depthReg    <= 1'b0;
      notFirstReg <= 1'b0;
      readyReg    <= 1'b0;
      rdValidReg  <= 1'b0;
      rdDataReg   <= 9'h000;
      fifoWData   <= 9'h000;
    end else begin
      if (cfgWrite) begin
        depthReg    <= wDataReg[`FHC_CTRL_DEPTH];
        notFirstReg <= wDataReg[`FHC_CTRL_NOTFIRST];
      end
      unique case (stateReg)
        FHC_IDLE: begin
          if (goStart) begin
            stateReg <= FHC_BUSY;
            opReg    <= goOp;
            if (goOp == FHC_OP_WR) begin
              fifoWData <= wDataReg[8:0];
            end
            if (goOp == FHC_OP_RD) begin
              rdValidReg <= 1'b0;
            end
          end
        end
        FHC_BUSY: begin
          // data captured on the last low cycle, one clock before read rises
          if (sif.lowEnd && opReg == FHC_OP_RD) begin
            rdDataReg  <= fifoRData;
            rdValidReg <= 1'b1;
          end
          if (sif.done) begin
            stateReg <= FHC_IDLE;
            if (opReg == FHC_OP_RST) begin
              readyReg <= 1'b1;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin drivers and cascade pulse count
  // ----------------------------------------------------------------
  wire lowNow = sif.low;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      write_n      <= 1'b1;
      read_n       <= 1'b1;
      reset_n      <= 1'b0;
      first_load_n <= 1'b1;
      cascade_in_n <= 1'b0;
      halfPrevReg  <= 1'b1;
      cascCntReg   <= 8'h00;
    end else begin
      write_n <= !(lowNow && opReg == FHC_OP_WR && !idle);
      read_n  <= !(lowNow && opReg == FHC_OP_RD && !idle);
      reset_n <= !(lowNow && opReg == FHC_OP_RST && !idle);
      // depth mode: level at reset picks first device, no reread
      if (depthReg) begin
        first_load_n <= notFirstReg;
      end else begin
        first_load_n <= !(lowNow && opReg == FHC_OP_RT && !idle);
      end
      // depth chain drives the cascade input, host leaves it idle
      cascade_in_n <= depthReg;
      halfPrevReg  <= halfSyn;
      if (depthReg && halfFell) begin
        cascCntReg <= cascCntReg + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  localparam int PW = `FHC_PULSE_CYC;
  chk_write_when_room: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(write_n) |-> $past(roomOk, 2))
    else $error("write strobe while full");
  chk_read_when_data: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(read_n) |-> $past(dataOk, 2))
    else $error("read strobe while empty");
  chk_single_xi_low: assert property (@(posedge clk) disable iff (!rst_n)
    (!reset_n && !depthReg) |-> !cascade_in_n)
    else $error("cascade input not low in single reset");
  chk_depth_no_reread: assert property (@(posedge clk) disable iff (!rst_n)
    (depthReg && $past(depthReg))
    |-> first_load_n == $past(notFirstReg))
    else $error("reread pulse in depth mode");
  chk_write_pulse_width: assert property (@(posedge clk)
    disable iff (!rst_n) $fell(write_n) |-> ##PW $rose(write_n))
    else $error("write strobe width wrong");
  chk_strobes_apart: assert property (@(posedge clk) disable iff (!rst_n)
    !(!write_n && !read_n) && !(!reset_n && (!write_n || !read_n)))
    else $error("two strobes low together");
  chk_depth_xi_idle: assert property (@(posedge clk) disable iff (!rst_n)
    depthReg |=> cascade_in_n)
    else $error("cascade input driven in depth mode");
  chk_fl_held_reset: assert property (@(posedge clk) disable iff (!rst_n)
    (depthReg && !reset_n) |-> first_load_n == notFirstReg)
    else $error("first load level wrong during reset");
  chk_read_recovery: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(read_n) |=> read_n[*5])
    else $error("read recovery too short");
  cov_write: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(write_n));
  cov_read: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(rdValidReg));
  cov_reset: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(reset_n));
  cov_cascade: cover property (@(posedge clk) disable iff (!rst_n)
    depthReg && halfFell);
endmodule : fhc_host

// ### fhc_fifo_model.sv
// Purpose: behavioural model of one cascadable async fifo device
// Assumes: host holds data from strobe start until next write
// Notes:   shortened depth; flag and data delays set by TFLAG
`timescale 1ns/1ps
module fhc_fifo_model #(
  parameter int DEPTH = 8,
  parameter int TFLAG = 60
) (
  input  wire logic               write_n,
  input  wire logic               read_n,
  input  wire logic               reset_n,
  input  wire logic               first_load_n,
  input  wire logic               cascade_in_n,
  input  wire fhc_pkg::fhc_word_t dataIn,
  output fhc_pkg::fhc_word_t      dataOut,
  output logic                    no_room_n,
  output logic                    nothing_stored_n,
  output logic                    half_level_n
);
  import fhc_pkg::*;
  fhc_word_t mem [DEPTH];
  int        wp, rp, cnt, xiSeen;
  logic      depthMode, wrOn, rdOn, wrOk, rdOk, wrLast, rdLast;
  logic      cascOut_n, halfRaw_n;

  // shared pin: cascade output in depth mode, half flag alone
  assign half_level_n = depthMode ? cascOut_n : halfRaw_n;

  initial begin
    dataOut = '0;
    {depthMode, wrOn, rdOn, wrOk, rdOk, wrLast, rdLast} = '0;
    {no_room_n, nothing_stored_n, cascOut_n, halfRaw_n} = 4'hB;
  end

  // --------------------------------------------------------
  // reset and cascade token
  // --------------------------------------------------------
  always @(reset_n) begin
    if (!reset_n) begin
      {wp, rp, cnt, xiSeen} = '0;
      no_room_n <= 1'b1;
      nothing_stored_n <= 1'b0;
      halfRaw_n <= 1'b1;
      cascOut_n <= 1'b1;
    end else begin
      depthMode = cascade_in_n;
      wrOn = !depthMode || !first_load_n;
      rdOn = wrOn;
    end
  end
  // re-read in single mode: read pointer back to the first location
  always @(negedge first_load_n) begin
    if (reset_n && !depthMode) begin
      rp = 0;
      cnt = wp;
      if (cnt > 0) nothing_stored_n <= #TFLAG 1'b1;
    end
  end
  always @(negedge cascade_in_n) begin
    if (depthMode && reset_n) begin
      xiSeen++;
      wrOn = 1'b1;
      if (xiSeen >= 2) rdOn = 1'b1;
    end
  end

  // --------------------------------------------------------
  // write and read strobes
  // --------------------------------------------------------
  always @(negedge write_n) begin
    wrOk = reset_n && wrOn && cnt < DEPTH;
    wrLast = wrOk && wp == DEPTH - 1;
    if (wrOk) begin
      mem[wp] = dataIn;
      wp = (wp + 1) % DEPTH;
      cnt++;
      if (cnt == DEPTH) no_room_n <= #TFLAG 1'b0;
      if (cnt > DEPTH / 2) halfRaw_n <= #TFLAG 1'b0;
    end
    if (wrLast && depthMode) begin
      cascOut_n <= #TFLAG 1'b0;
      wrOn = 1'b0;
    end
  end
  always @(posedge write_n) begin
    if (wrOk) nothing_stored_n <= #TFLAG 1'b1;
    if (wrLast && depthMode) cascOut_n <= #TFLAG 1'b1;
  end
  always @(negedge read_n) begin
    rdOk = reset_n && rdOn && cnt > 0;
    rdLast = rdOk && rp == DEPTH - 1;
    if (rdOk) begin
      dataOut <= #TFLAG mem[rp];
      rp = (rp + 1) % DEPTH;
      cnt--;
      if (cnt == 0) nothing_stored_n <= #TFLAG 1'b0;
    end
    if (rdLast && depthMode) begin
      cascOut_n <= #TFLAG 1'b0;
      rdOn = 1'b0;
    end
  end
  always @(posedge read_n) begin
    // released outputs must not look like held data
    dataOut <= #5 ~dataOut;
    if (rdOk) no_room_n <= #TFLAG 1'b1;
    if (rdOk && cnt <= DEPTH / 2) halfRaw_n <= #TFLAG 1'b1;
    if (rdLast && depthMode) cascOut_n <= #TFLAG 1'b1;
  end
endmodule : fhc_fifo_model

// ### tb.sv
// Purpose: self-checking bench of the fifo host controller
// Assumes: one fifo model, depth shortened to DEPTH words
// Notes:   cascade input pulses come from the bench in depth mode
`timescale 1ns/1ps
`include "fhc_cfg.svh"
module tb;
  import fhc_pkg::*;
  localparam int DEPTH = 8;
  typedef struct {
    logic        wr;
    logic [3:0]  a;
    logic [31:0] d;
    logic [1:0]  r;
    logic [31:0] m;
    logic [31:0] e;
  } fhc_row_t;
  logic        clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, xiPulse_n;
  logic        write_n, read_n, reset_n, first_load_n, cascade_in_n;
  logic        no_room_n, nothing_stored_n, half_level_n;
  logic [3:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  fhc_word_t   fifoWData, fifoRData;
  int          miscompares, check_count;
  fhc_row_t    rows [12];

  fhc_host u_dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .write_n, .read_n,
    .reset_n, .first_load_n, .cascade_in_n, .fifoWData, .fifoRData,
    .no_room_n, .nothing_stored_n, .half_level_n);
  fhc_fifo_model #(.DEPTH(DEPTH), .TFLAG(150)) u_fifo (.write_n,
    .read_n, .reset_n, .first_load_n,
    .cascade_in_n(cascade_in_n & xiPulse_n),
    .dataIn(fifoWData), .dataOut(fifoRData), .no_room_n,
    .nothing_stored_n, .half_level_n);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  task results;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  task chk(input string name, input logic [31:0] seen,
           input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // valid held until its own ready; ready for answer held until seen
  task automatic axi(input logic wr, input logic [3:0] a,
    input logic [31:0] d, output logic [1:0] rs, output logic [31:0] rq);
    logic pa, pw, par, pr;
    int   n;
    @(posedge clk);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    n = 0;
    pr = 1'b0;
    while (!pr) begin
      @(negedge clk);
      n++;
      if (n > 400) begin
        miscompares++;
        results();
      end
      pa = s_axi_awvalid && s_axi_awready;
      pw = s_axi_wvalid && s_axi_wready;
      par = s_axi_arvalid && s_axi_arready;
      pr = wr ? s_axi_bvalid : s_axi_rvalid;
      rs = wr ? s_axi_bresp : s_axi_rresp;
      rq = s_axi_rdata;
      @(posedge clk);
      if (pa) s_axi_awvalid <= 1'b0;
      if (pw) s_axi_wvalid <= 1'b0;
      if (par) s_axi_arvalid <= 1'b0;
      if (pr) s_axi_bready <= 1'b0;
      if (pr) s_axi_rready <= 1'b0;
    end
  endtask : axi
  task automatic rreg(input logic [3:0] a, output logic [31:0] v);
    logic [1:0] rs;
    axi(1'b0, a, '0, rs, v);
  endtask : rreg
  task automatic wreg(input logic [3:0] a, input logic [31:0] d,
                      input logic [1:0] er);
    logic [1:0]  rs;
    logic [31:0] v;
    int          n;
    axi(1'b1, a, d, rs, v);
    chk("bresp", {30'h0, rs}, {30'h0, er});
    v = 32'h1;
    n = 0;
    while (er === `FHC_RESP_OKAY && v[`FHC_ST_BUSY] !== 1'b0) begin
      rreg(`FHC_OFF_STATUS, v);
      n++;
      if (n > 60) begin
        miscompares++;
        results();
      end
    end
  endtask : wreg
  task xiPulse;
    @(posedge clk);
    xiPulse_n <= 1'b0;
    repeat (25) @(posedge clk);
    xiPulse_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask : xiPulse

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    rows = '{
      '{1'b0, `FHC_OFF_CTRL,   32'h0,   2'h0, 32'hF,     32'h0},
      '{1'b1, `FHC_OFF_WDATA,  32'h55,  2'h2, 32'h0,     32'h0},
      '{1'b1, `FHC_OFF_CTRL,   32'h4,   2'h0, 32'h0,     32'h0},
      '{1'b0, `FHC_OFF_STATUS, 32'h0,   2'h0, 32'h1F,    32'h14},
      '{1'b1, `FHC_OFF_RDCMD,  32'h1,   2'h2, 32'h0,     32'h0},
      '{1'b1, `FHC_OFF_WDATA,  32'h1A5, 2'h0, 32'h0,     32'h0},
      '{1'b0, `FHC_OFF_STATUS, 32'h0,   2'h0, 32'h1F,    32'h10},
      '{1'b1, `FHC_OFF_RDCMD,  32'h1,   2'h0, 32'h0,     32'h0},
      '{1'b1, `FHC_OFF_CTRL,   32'h8,   2'h0, 32'h0,     32'h0},
      '{1'b1, `FHC_OFF_RDCMD,  32'h1,   2'h0, 32'h0,     32'h0},
      '{1'b0, `FHC_OFF_RDCMD,  32'h0,   2'h0, 32'h101FF, 32'h101A5},
      '{1'b0, `FHC_OFF_WDATA,  32'h0,   2'h2, 32'hFFFFFFFF, 32'h0}};
    {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {miscompares, check_count, s_axi_wdata} = '0;
    xiPulse_n = 1'b1;
    repeat (5) @(posedge clk);
    chk("strobes", {write_n, read_n, reset_n, cascade_in_n}, 4'hC);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) begin
        wreg(rows[i].a, rows[i].d, rows[i].r);
      end else begin
        axi(1'b0, rows[i].a, '0, r, q);
        chk("rresp", {30'h0, r}, {30'h0, rows[i].r});
        chk("rdata", q & rows[i].m, rows[i].e);
      end
    end
    // single mode: fill past half to full, then drain in order
    wreg(`FHC_OFF_CTRL, 32'h4, `FHC_RESP_OKAY);
    for (int i = 0; i < DEPTH; i++) begin
      wreg(`FHC_OFF_WDATA, 32'h100 + i * 7, `FHC_RESP_OKAY);
      rreg(`FHC_OFF_STATUS, q);
      chk("half", q[`FHC_ST_HALF], (i + 1) > DEPTH / 2);
    end
    chk("full", q[`FHC_ST_FULL], 1'b1);
    wreg(`FHC_OFF_WDATA, 32'hAA, `FHC_RESP_SLVERR);
    for (int i = 0; i < DEPTH; i++) begin
      wreg(`FHC_OFF_RDCMD, 32'h1, `FHC_RESP_OKAY);
      rreg(`FHC_OFF_RDCMD, q);
      chk("data", q[8:0], 9'h100 + i * 7);
      rreg(`FHC_OFF_STATUS, q);
      chk("half", q[`FHC_ST_HALF], (DEPTH - 1 - i) > DEPTH / 2);
    end
    chk("empty", q[`FHC_ST_EMPTY], 1'b1);
    // depth mode, first device: token at last location both ways
    wreg(`FHC_OFF_CTRL, 32'h5, `FHC_RESP_OKAY);
    wreg(`FHC_OFF_CTRL, 32'h9, `FHC_RESP_SLVERR);
    for (int i = 0; i < DEPTH; i++)
      wreg(`FHC_OFF_WDATA, 32'h40 + i, `FHC_RESP_OKAY);
    rreg(`FHC_OFF_STATUS, q);
    chk("cascade", q[15:8], 8'h1);
    chk("half", q[`FHC_ST_HALF], 1'b0);
    for (int i = 0; i < DEPTH; i++) begin
      wreg(`FHC_OFF_RDCMD, 32'h1, `FHC_RESP_OKAY);
      rreg(`FHC_OFF_RDCMD, q);
      chk("data", q[8:0], 9'h40 + i);
    end
    rreg(`FHC_OFF_STATUS, q);
    chk("cascade", q[15:8], 8'h2);
    // depth mode, later device: waits for token pulses
    wreg(`FHC_OFF_CTRL, 32'h7, `FHC_RESP_OKAY);
    wreg(`FHC_OFF_WDATA, 32'hC3, `FHC_RESP_OKAY);
    rreg(`FHC_OFF_STATUS, q);
    chk("empty", q[`FHC_ST_EMPTY], 1'b1);
    xiPulse();
    wreg(`FHC_OFF_WDATA, 32'hC3, `FHC_RESP_OKAY);
    rreg(`FHC_OFF_STATUS, q);
    chk("empty", q[`FHC_ST_EMPTY], 1'b0);
    wreg(`FHC_OFF_RDCMD, 32'h1, `FHC_RESP_OKAY);
    rreg(`FHC_OFF_STATUS, q);
    chk("empty", q[`FHC_ST_EMPTY], 1'b0);
    xiPulse();
    wreg(`FHC_OFF_RDCMD, 32'h1, `FHC_RESP_OKAY);
    rreg(`FHC_OFF_RDCMD, q);
    chk("data", q[8:0], 9'hC3);
    results();
  end
endmodule : tb
